// [logic/sww_map.svh]
// Offsets, field positions, reset values and timing counts of the sleep/wake watchdog.
// Assumes a 250 MHz mclk; register indices become byte addresses by times four.
`ifndef SWW_MAP_SVH
`define SWW_MAP_SVH

// Register indices (byte address = index * 4)
`define SWW_IDX_RESET_CAUSE_CONTROL    24'h000740
`define SWW_IDX_OSCILLATOR_CONTROL  24'h000742
`define SWW_IDX_OSCILLATOR_TUNING  24'h000744
`define SWW_IDX_MODULE_DISABLE_FIRST    24'h000770
`define SWW_IDX_MODULE_DISABLE_SECOND    24'h000772
`define SWW_IDX_OSCILLATOR_CONFIG_WORD    24'hf80000
`define SWW_IDX_WATCHDOG_CONFIG_WORD    24'hf80002
`define SWW_IDX_FBOR    24'hf80004
`define SWW_IDX_FBS     24'hf80006
`define SWW_IDX_FSS     24'hf80008
`define SWW_IDX_FGS     24'hf8000a
`define SWW_IDX_DEBUG_CONFIG_WORD    24'hf8000c

// Slots of the plain register array
`define SWW_SLOT_OSCILLATOR_CONFIG_WORD   4'h3
`define SWW_SLOT_WATCHDOG_CONFIG_WORD   4'h4
`define SWW_SLOT_FBOR   4'h5

// Reset-control fields
`define SWW_RC_TRAPR    15
`define SWW_RC_EXTR     7
`define SWW_RC_WATCHDOG_SOFTWARE_ENABLE   5
`define SWW_RC_WATCHDOG_TIMEOUT_FLAG     4
`define SWW_RC_SLEEP    3
`define SWW_RC_IDLE     2
`define SWW_RC_BOR      1
`define SWW_RC_POR      0
`define SWW_RESET_CAUSE_CONTROL_WMASK  16'h80ff

// Oscillator-control fields
`define SWW_OC_COSC     14:12
`define SWW_OC_LOCK     5
`define SWW_OC_CF       3
`define SWW_OC_LPOSCEN  1
`define SWW_OC_NOSC     10:8
`define SWW_OC_OSWEN    0
`define SWW_OSCILLATOR_CONTROL_WMASK 16'h070b
`define SWW_OSCILLATOR_TUNING_WMASK 16'h003f

// Config word fields
`define SWW_CFG_WATCHDOG_CONFIG_ENABLE  15
`define SWW_CFG_BOREN   7
`define SWW_CFG_FSCMOFF 15

// Current-oscillator codes
`define SWW_OSC_LP      3'h0
`define SWW_OSC_FRC     3'h1
`define SWW_OSC_LOW_POWER_RC_OSCILLATOR    3'h2
`define SWW_OSC_XTAL    3'h3
`define SWW_OSC_PLL     3'h4
`define SWW_OSC_EC      3'h5
`define SWW_OSC_ERC     3'h6

// Reset values
`define SWW_WATCHDOG_CONFIG_WORD_RST    16'h8000
`define SWW_COSC_RST    3'h1

// Timing
`define SWW_CLK_NS      4
`define SWW_POWER_ON_DELAY_NS     10000
`define SWW_POWER_ON_DELAY_CYC    ((`SWW_POWER_ON_DELAY_NS + `SWW_CLK_NS - 1) / `SWW_CLK_NS)
`define SWW_PLL_SETTLE_DELAY_NS    50000
`define SWW_PLL_SETTLE_DELAY_CYC   ((`SWW_PLL_SETTLE_DELAY_NS + `SWW_CLK_NS - 1) / `SWW_CLK_NS)
`define SWW_POWER_UP_TIMER_DELAY_NS    16000
`define SWW_POWER_UP_TIMER_DELAY_CYC   ((`SWW_POWER_UP_TIMER_DELAY_NS + `SWW_CLK_NS - 1) / `SWW_CLK_NS)

`endif

// [logic/sww_pkg.sv]
// Types of the sleep/wake watchdog block.
// Assumes nothing beyond a SystemVerilog compiler.
package sww_pkg;
	typedef logic [2:0] sww_osc_t;

	typedef enum logic [2:0] {
		S_RUN, S_IDLE, S_SLEEP, S_POR, S_LOCK, S_POWER_UP_TIMER, S_CHECK, S_STALL
	} sww_state_e;

	typedef struct packed {
		sww_state_e        st;
		logic [15:0]       reset_cause_control;
		logic [15:0]       oscillator_control;
		logic [9:0][15:0]  misc;
		logic              lpRan;
		logic              pendIsr;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic              cpuClkEn;
		logic              perClkEn;
		logic              oscRunEn;
		logic              lprcRunEn;
		logic              fscmActive;
		logic              devReset;
		logic              isrGo;
		logic              clkFailTrap;
	} sww_top_s;
endpackage

// [logic/sww_delay.sv]
// One-shot delay counter: done pulses count cycles after start.
// Assumes count is at least one; a new start restarts the count.
`timescale 1ns/1ps
module sww_delay #(
	parameter int W = 16
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         start,
	input  wire logic [W-1:0] count,
	output logic              done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
		logic         done;
	} sww_dly_s;

	sww_dly_s r, n;

	// Down counter, restart wins over a count in progress
	always_comb begin
		n = r;
		n.done = 1'b0;
		if (start) begin
			n.cnt = count;
			n.busy = 1'b1;
		end else if (r.busy) begin
			n.cnt = r.cnt - 1'b1;
			if (r.cnt == {{(W-1){1'b0}}, 1'b1}) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign done = r.done;
endmodule

// [logic/sww_wdt.sv]
// Watchdog counter advanced by ticks of the low-power RC oscillator.
// Assumes tick is a one-cycle pulse already in the mclk domain.
`timescale 1ns/1ps
module sww_wdt #(
	parameter int W = 16
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic tick,
	input  wire logic en,
	input  wire logic clr,
	output logic      ovf
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         ovf;
	} sww_wdt_s;

	sww_wdt_s r, n;

	// Count on RC ticks only, so a dead crystal cannot stop it
	always_comb begin
		n = r;
		n.ovf = 1'b0;
		if (clr) begin
			n.cnt = '0;
		end else if (en && tick) begin
			n.cnt = r.cnt + 1'b1;
			n.ovf = &r.cnt;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign ovf = r.ovf;

	property p_clr;
		@(posedge mclk) disable iff (rst) clr |=> (r.cnt == '0) && !ovf;
	endproperty
	a_clr: assert property (p_clr) else $error("count not cleared");

	property p_ovf;
		@(posedge mclk) disable iff (rst)
		en && tick && !clr && (&r.cnt) |=> ovf && (r.cnt == '0);
	endproperty
	a_ovf: assert property (p_ovf) else $error("missed overflow");
endmodule

// [logic/sww_top.sv]
// Watchdog, sleep/idle control and wake-up clock sequencing, APB slave.
// Assumes the core signals instructions as one-cycle pulses; the RC tick is in mclk domain.
// Overview of operation
// - Watchdog counts ticks of its own RC oscillator, not the system clock.
// - Watchdog on when config enable bit is 1; erased default is 1.
// - With config enable 0, software enable bit 5 of reset-control turns it on.
// - Enabled watchdog counts up; overflow while awake forces full device reset.
// - Software clears the watchdog periodically; clear instruction zeroes the count.
// - Overflow in sleep wakes instead; sleep and timeout flags both set.
// - Power-save instruction enters sleep or idle, chosen by its operand.
// - Sleep gates CPU and peripheral clocks and stops on-chip oscillator.
// - Clock monitor off in sleep; RC oscillator runs while watchdog is on.
// - Enabled brown-out detection keeps working in sleep and can reset.
// - Sleep ends on enabled interrupt, any reset, or watchdog timeout.
// - Wake restarts the oscillator named by the current-oscillator field.
// - Crystal waits for start-up, PLL for lock; power and lock delays apply.
// - External, fast RC, low-power RC, external RC: only power-on delay.
// - Low-power crystal that ran through sleep: only power-on delay.
// - Interrupt wake branches to the service routine and sets sleep flag.
// - Clock still dead after delays: monitor traps to fast RC, else stall.
// - Any reset wakes; non-power-on reset sets sleep flag, power-on clears.
`timescale 1ns/1ps
`include "sww_map.svh"
module sww_top #(
	parameter int WDT_W     = 16,
	parameter int PLL_SETTLE_DELAY_CYC = `SWW_PLL_SETTLE_DELAY_CYC,
	parameter int POWER_UP_TIMER_DELAY_CYC = `SWW_POWER_UP_TIMER_DELAY_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [25:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        clrWdtInstr,
	input  wire logic        pwrSavInstr,
	input  wire logic        pwrSavSleep,
	input  wire logic        intWake,
	input  wire logic        porEvt,
	input  wire logic        borEvt,
	input  wire logic        mclrEvt,
	input  wire logic        lprcTick,
	input  wire logic        oscStable,
	input  wire logic        pllLock,
	output logic             cpuClkEn,
	output logic             perClkEn,
	output logic             oscRunEn,
	output logic             lprcRunEn,
	output logic             fscmActive,
	output logic             devReset,
	output logic             isrGo,
	output logic             clkFailTrap,
	output sww_pkg::sww_osc_t currentOsc
);
	import sww_pkg::*;

	sww_top_s    r, n;
	logic        wdtOvf;
	logic        dDone;
	logic        dStart;
	logic [15:0] dCount;
	logic [15:0] rd;
	logic [3:0]  slot;
	logic        hit;
	logic        isMisc;
	logic        wr;
	logic        wdtEn;
	logic        boren;
	logic        fscmEn;
	logic        resetEvt;
	logic        ok;
	logic        fast;
	sww_osc_t    cosc;

	// Configuration-driven enables
	assign wdtEn  = r.misc[`SWW_SLOT_WATCHDOG_CONFIG_WORD][`SWW_CFG_WATCHDOG_CONFIG_ENABLE] | r.reset_cause_control[`SWW_RC_WATCHDOG_SOFTWARE_ENABLE];
	assign boren  = r.misc[`SWW_SLOT_FBOR][`SWW_CFG_BOREN];
	assign fscmEn = !r.misc[`SWW_SLOT_OSCILLATOR_CONFIG_WORD][`SWW_CFG_FSCMOFF];
	assign cosc   = r.oscillator_control[`SWW_OC_COSC];

	// Any reset source; a timeout in sleep wakes rather than resets
	assign resetEvt = porEvt | (borEvt & boren) | mclrEvt
		| (wdtOvf & (r.st != S_SLEEP));

	// Clock ready check for the restarted source
	assign ok = (cosc == `SWW_OSC_PLL) ? pllLock : oscStable;
	assign fast = (cosc == `SWW_OSC_EC) || (cosc == `SWW_OSC_FRC)
		|| (cosc == `SWW_OSC_LOW_POWER_RC_OSCILLATOR) || (cosc == `SWW_OSC_ERC)
		|| ((cosc == `SWW_OSC_LP) && r.lpRan);

	sww_wdt #(
		.W (WDT_W)
	) u_wdt (
		.mclk (mclk),
		.rst  (rst),
		.tick (lprcTick),
		.en   (wdtEn),
		.clr  (clrWdtInstr | resetEvt),
		.ovf  (wdtOvf)
	);

	sww_delay #(
		.W (16)
	) u_dly (
		.mclk  (mclk),
		.rst   (rst),
		.start (dStart),
		.count (dCount),
		.done  (dDone)
	);

	// Register read decode; misaligned or unknown address answers with an error
	always_comb begin
		rd = 16'h0000;
		slot = 4'h0;
		hit = 1'b1;
		isMisc = 1'b1;
		case (paddr[25:2])
			`SWW_IDX_RESET_CAUSE_CONTROL: isMisc = 1'b0;
			`SWW_IDX_OSCILLATOR_CONTROL: isMisc = 1'b0;
			`SWW_IDX_OSCILLATOR_TUNING: slot = 4'h0;
			`SWW_IDX_MODULE_DISABLE_FIRST: slot = 4'h1;
			`SWW_IDX_MODULE_DISABLE_SECOND: slot = 4'h2;
			`SWW_IDX_OSCILLATOR_CONFIG_WORD: slot = `SWW_SLOT_OSCILLATOR_CONFIG_WORD;
			`SWW_IDX_WATCHDOG_CONFIG_WORD: slot = `SWW_SLOT_WATCHDOG_CONFIG_WORD;
			`SWW_IDX_FBOR: slot = `SWW_SLOT_FBOR;
			`SWW_IDX_FBS: slot = 4'h6;
			`SWW_IDX_FSS: slot = 4'h7;
			`SWW_IDX_FGS: slot = 4'h8;
			`SWW_IDX_DEBUG_CONFIG_WORD: slot = 4'h9;
			default: hit = 1'b0;
		endcase
		if (paddr[1:0] != 2'b00) begin
			hit = 1'b0;
		end
		if (!hit) begin
			rd = 16'h0000;
		end else if (isMisc) begin
			rd = r.misc[slot];
		end else if (paddr[25:2] == `SWW_IDX_RESET_CAUSE_CONTROL) begin
			rd = r.reset_cause_control;
		end else begin
			rd = r.oscillator_control;
		end
	end

	// Writes take effect on the access edge
	assign wr = psel && penable && r.pready && pwrite && hit;

	// Next state: bus, flags, power state machine, clock enables
	always_comb begin
		n = r;
		n.devReset = 1'b0;
		n.isrGo = 1'b0;
		n.clkFailTrap = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		dStart = 1'b0;
		dCount = 16'h0000;

		// Zero-wait answer: ready in the first access cycle
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.pslverr = !hit;
			n.prdata = {16'h0000, rd};
		end

		// Software writes first, so a hardware set in the same cycle wins
		if (wr && !isMisc && (paddr[25:2] == `SWW_IDX_RESET_CAUSE_CONTROL)) begin
			n.reset_cause_control = (r.reset_cause_control & ~`SWW_RESET_CAUSE_CONTROL_WMASK) | (pwdata[15:0] & `SWW_RESET_CAUSE_CONTROL_WMASK);
		end else if (wr && !isMisc) begin
			n.oscillator_control = (r.oscillator_control & ~`SWW_OSCILLATOR_CONTROL_WMASK) | (pwdata[15:0] & `SWW_OSCILLATOR_CONTROL_WMASK);
			// Switch takes the next-oscillator field at once; no switch delay is modelled
			if (pwdata[`SWW_OC_OSWEN]) begin
				n.oscillator_control[`SWW_OC_COSC] = pwdata[`SWW_OC_NOSC];
				n.oscillator_control[`SWW_OC_OSWEN] = 1'b0;
			end
		end else if (wr && (slot == 4'h0)) begin
			n.misc[0] = pwdata[15:0] & `SWW_OSCILLATOR_TUNING_WMASK;
		end else if (wr) begin
			n.misc[slot] = pwdata[15:0];
		end
		n.oscillator_control[`SWW_OC_LOCK] = pllLock;

		// Power state machine
		case (r.st)
			S_RUN: begin
				if (pwrSavInstr && pwrSavSleep) begin
					n.st = S_SLEEP;
					n.lpRan = (cosc == `SWW_OSC_LP) && r.oscillator_control[`SWW_OC_LPOSCEN];
				end else if (pwrSavInstr) begin
					n.st = S_IDLE;
				end
			end
			S_IDLE: begin
				if (intWake) begin
					n.st = S_RUN;
					n.isrGo = 1'b1;
					n.reset_cause_control[`SWW_RC_IDLE] = 1'b1;
				end
			end
			S_SLEEP: begin
				if (intWake || wdtOvf) begin
					n.st = S_POR;
					dStart = 1'b1;
					dCount = 16'(`SWW_POWER_ON_DELAY_CYC);
					n.reset_cause_control[`SWW_RC_SLEEP] = 1'b1;
					n.pendIsr = intWake && !wdtOvf;
				end
				if (wdtOvf) begin
					n.reset_cause_control[`SWW_RC_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
				end
			end
			S_POR: begin
				if (dDone && fast) begin
					n.st = S_RUN;
				end else if (dDone && (cosc == `SWW_OSC_PLL)) begin
					n.st = S_LOCK;
					dStart = 1'b1;
					dCount = 16'(PLL_SETTLE_DELAY_CYC);
				end else if (dDone) begin
					n.st = S_POWER_UP_TIMER;
					dStart = 1'b1;
					dCount = 16'(POWER_UP_TIMER_DELAY_CYC);
				end
			end
			S_LOCK: begin
				if (dDone) begin
					n.st = S_POWER_UP_TIMER;
					dStart = 1'b1;
					dCount = 16'(POWER_UP_TIMER_DELAY_CYC);
				end
			end
			S_POWER_UP_TIMER: begin
				if (dDone) begin
					n.st = S_CHECK;
				end
			end
			S_CHECK: begin
				if (ok) begin
					n.st = S_RUN;
				end else if (fscmEn) begin
					n.st = S_RUN;
					n.clkFailTrap = 1'b1;
					n.reset_cause_control[`SWW_RC_TRAPR] = 1'b1;
					n.oscillator_control[`SWW_OC_CF] = 1'b1;
					n.oscillator_control[`SWW_OC_COSC] = `SWW_OSC_FRC;
				end else begin
					n.st = S_STALL;
				end
			end
			S_STALL: begin
				if (ok) begin
					n.st = S_RUN;
				end
			end
			default: n.st = S_RUN;
		endcase

		// Pending interrupt is serviced once the clock is back
		if ((r.st != S_RUN) && (r.st != S_IDLE) && (n.st == S_RUN)) begin
			n.isrGo = r.pendIsr;
			n.pendIsr = 1'b0;
		end

		// Resets override everything and restart through the power-on delay
		if (resetEvt) begin
			n.devReset = 1'b1;
			n.st = S_POR;
			dStart = 1'b1;
			dCount = 16'(`SWW_POWER_ON_DELAY_CYC);
			n.pendIsr = 1'b0;
			n.isrGo = 1'b0;
			if (porEvt) begin
				n.reset_cause_control[`SWW_RC_POR] = 1'b1;
				n.reset_cause_control[`SWW_RC_SLEEP] = 1'b0;
			end else begin
				if (r.st == S_SLEEP) begin
					n.reset_cause_control[`SWW_RC_SLEEP] = 1'b1;
				end
				if (r.st == S_IDLE) begin
					n.reset_cause_control[`SWW_RC_IDLE] = 1'b1;
				end
				if (borEvt && boren) begin
					n.reset_cause_control[`SWW_RC_BOR] = 1'b1;
				end
				if (mclrEvt) begin
					n.reset_cause_control[`SWW_RC_EXTR] = 1'b1;
				end
				if (wdtOvf) begin
					n.reset_cause_control[`SWW_RC_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
				end
			end
		end

		// Clock gating from the next state keeps outputs aligned with it
		n.cpuClkEn = (n.st == S_RUN);
		n.perClkEn = (n.st == S_RUN) || (n.st == S_IDLE);
		n.oscRunEn = (n.st != S_SLEEP) || n.lpRan;
		n.lprcRunEn = wdtEn || (cosc == `SWW_OSC_LOW_POWER_RC_OSCILLATOR);
		n.fscmActive = fscmEn && (n.st != S_SLEEP);
	end

	// State register; power-on values after the asynchronous reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.reset_cause_control[`SWW_RC_POR] <= 1'b1;
			r.oscillator_control[`SWW_OC_COSC] <= `SWW_COSC_RST;
			r.misc[`SWW_SLOT_WATCHDOG_CONFIG_WORD] <= `SWW_WATCHDOG_CONFIG_WORD_RST;
			r.cpuClkEn <= 1'b1;
			r.perClkEn <= 1'b1;
			r.oscRunEn <= 1'b1;
			r.lprcRunEn <= 1'b1;
			r.fscmActive <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign prdata      = r.prdata;
	assign pready      = r.pready;
	assign pslverr     = r.pslverr;
	assign cpuClkEn    = r.cpuClkEn;
	assign perClkEn    = r.perClkEn;
	assign oscRunEn    = r.oscRunEn;
	assign lprcRunEn   = r.lprcRunEn;
	assign fscmActive  = r.fscmActive;
	assign devReset    = r.devReset;
	assign isrGo       = r.isrGo;
	assign clkFailTrap = r.clkFailTrap;
	assign currentOsc  = r.oscillator_control[`SWW_OC_COSC];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_wdtReset;
		wdtOvf && (r.st != S_SLEEP) |=> devReset && (r.st == S_POR);
	endproperty
	a_wdtReset: assert property (p_wdtReset) else $error("no reset on timeout");
	property p_wdtWake;
		wdtOvf && (r.st == S_SLEEP) && !resetEvt |=>
			!devReset && r.reset_cause_control[`SWW_RC_WATCHDOG_TIMEOUT_FLAG] && r.reset_cause_control[`SWW_RC_SLEEP];
	endproperty
	a_wdtWake: assert property (p_wdtWake) else $error("bad timeout wake");
	property p_enable;
		r.misc[`SWW_SLOT_WATCHDOG_CONFIG_WORD][`SWW_CFG_WATCHDOG_CONFIG_ENABLE] |=> lprcRunEn;
	endproperty
	a_enable: assert property (p_enable) else $error("rc clock off with watchdog on");
	property p_sleepGate;
		(r.st == S_SLEEP) |-> !cpuClkEn && !perClkEn && !fscmActive;
	endproperty
	a_sleepGate: assert property (p_sleepGate) else $error("clock alive in sleep");
	property p_idle;
		(r.st == S_IDLE) |-> !cpuClkEn && perClkEn;
	endproperty
	a_idle: assert property (p_idle) else $error("bad idle gating");
	property p_fastWake;
		(r.st == S_POR) && dDone && fast && !resetEvt |=> (r.st == S_RUN) && cpuClkEn;
	endproperty
	a_fastWake: assert property (p_fastWake) else $error("extra delay");
	property p_intWake;
		(r.st == S_SLEEP) && intWake && !wdtOvf && !resetEvt |=>
			r.reset_cause_control[`SWW_RC_SLEEP] && (r.st == S_POR);
	endproperty
	a_intWake: assert property (p_intWake) else $error("interrupt wake lost");
	property p_por;
		porEvt |=> !r.reset_cause_control[`SWW_RC_SLEEP] && r.reset_cause_control[`SWW_RC_POR] && devReset;
	endproperty
	a_por: assert property (p_por) else $error("power-on flags wrong");
	property p_bor;
		borEvt && boren |=> devReset ##1 !cpuClkEn;
	endproperty
	a_bor: assert property (p_bor) else $error("brown-out ignored");
	property p_trap;
		(r.st == S_CHECK) && !ok && fscmEn && !resetEvt |=>
			clkFailTrap && (currentOsc == `SWW_OSC_FRC);
	endproperty
	a_trap: assert property (p_trap) else $error("no clock-fail trap");

	// Pending flag spans the whole wake delay, so no long delay range is needed
	c_intWake: cover property (r.pendIsr ##1 isrGo);
	c_wdtWake: cover property ((r.st == S_SLEEP) && wdtOvf);
	c_trap: cover property (clkFailTrap);
	c_idle: cover property ((r.st == S_IDLE) ##1 (r.st == S_RUN));
endmodule

// [bench/sww_core_model.sv]
// CPU core stand-in that issues watchdog-clear and power-save instructions.
// Assumes one bench thread calls its tasks; each pulse lasts one mclk cycle.
`timescale 1ns/1ps
module sww_core_model (
	input  wire logic mclk,
	output logic      clrWdtInstr,
	output logic      pwrSavInstr,
	output logic      pwrSavSleep
);
	// Idle at time zero so the block sees no stray instruction
	initial begin
		clrWdtInstr = 1'b0;
		pwrSavInstr = 1'b0;
		pwrSavSleep = 1'b0;
	end

	// Periodic feed that keeps the watchdog from expiring
	task automatic clear_wdt();
		@(posedge mclk);
		clrWdtInstr <= 1'b1;
		@(posedge mclk);
		clrWdtInstr <= 1'b0;
	endtask

	// Operand picks sleep or idle; the selected oscillator is left as it is
	task automatic power_save(input logic sleep);
		@(posedge mclk);
		pwrSavInstr <= 1'b1;
		pwrSavSleep <= sleep;
		@(posedge mclk);
		pwrSavInstr <= 1'b0;
	endtask
endmodule

// [bench/sleep_wake_watchdog_tb_top.sv]
// Self-checking bench of the sleep/wake watchdog block.
// Assumes the design under logic/ and the core stand-in; lock and power-up counts shortened.
`timescale 1ns/1ps
module sleep_wake_watchdog_tb_top;
	import sww_pkg::*;
	typedef struct {
		logic [25:0] addr;
		logic        wr;
		logic [31:0] data;
		logic [31:0] exp;
		logic        err;
	} sww_row_s;

	logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
	logic [25:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        clrWdtInstr, pwrSavInstr, pwrSavSleep, intWake, porEvt, borEvt, mclrEvt;
	logic        lprcTick, oscStable, pllLock, cpuClkEn, perClkEn, oscRunEn, lprcRunEn;
	logic        fscmActive, devReset, isrGo, clkFailTrap, er;
	sww_osc_t    currentOsc;
	int          miscompares, checks_done, resetSeen, isrSeen, trapSeen, n, i;

	// Plain register traffic: reset values, masks, refusals
	sww_row_s rows [9] = '{
		'{26'h0001d00, 1'b0, 32'h0, 32'h00000001, 1'b0},
		'{26'h3e00008, 1'b0, 32'h0, 32'h00008000, 1'b0},
		'{26'h0001d08, 1'b0, 32'h0, 32'h00001000, 1'b0},
		'{26'h0001d10, 1'b1, 32'hffffffff, 32'h0, 1'b0},
		'{26'h0001d10, 1'b0, 32'h0, 32'h0000003f, 1'b0},
		'{26'h0001dc0, 1'b1, 32'h0000a5a5, 32'h0, 1'b0},
		'{26'h0001dc0, 1'b0, 32'h0, 32'h0000a5a5, 1'b0},
		'{26'h0000004, 1'b0, 32'h0, 32'h0, 1'b1},
		'{26'h0001d02, 1'b1, 32'h1, 32'h0, 1'b1}
	};

	sww_core_model core_u (.mclk(mclk), .clrWdtInstr(clrWdtInstr),
		.pwrSavInstr(pwrSavInstr), .pwrSavSleep(pwrSavSleep));

	sww_top #(.WDT_W(4), .PLL_SETTLE_DELAY_CYC(20), .POWER_UP_TIMER_DELAY_CYC(20)) dut_u (
		.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clrWdtInstr(clrWdtInstr), .pwrSavInstr(pwrSavInstr),
		.pwrSavSleep(pwrSavSleep), .intWake(intWake), .porEvt(porEvt), .borEvt(borEvt),
		.mclrEvt(mclrEvt), .lprcTick(lprcTick), .oscStable(oscStable), .pllLock(pllLock),
		.cpuClkEn(cpuClkEn), .perClkEn(perClkEn), .oscRunEn(oscRunEn),
		.lprcRunEn(lprcRunEn), .fscmActive(fscmActive), .devReset(devReset),
		.isrGo(isrGo), .clkFailTrap(clkFailTrap), .currentOsc(currentOsc));

	// 250 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Pulse counters, so one-cycle outputs are never missed
	always @(posedge mclk) begin
		if (devReset === 1'b1) resetSeen++;
		if (isrGo === 1'b1) isrSeen++;
		if (clkFailTrap === 1'b1) trapSeen++;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic [25:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h1, {31'h0, pready});
	endtask

	task automatic ticks(input int k);
		repeat (k) begin
			@(posedge mclk);
			lprcTick <= 1'b1;
			@(posedge mclk);
			lprcTick <= 1'b0;
		end
	endtask

	// Bounded wait for the CPU clock to come back
	task automatic wait_cpu(output int c);
		c = 0;
		do begin
			@(posedge mclk);
			c++;
		end while (cpuClkEn !== 1'b1 && c < 4000);
	endtask

	// Enter sleep, wake by source k (4 = watchdog expiry), then read the flags
	task automatic sleep_case(input int k, input logic [31:0] flags, input logic [31:0] mask,
		output int c);
		apb(26'h0001d00, 1'b1, 32'h0, rd, er);
		core_u.clear_wdt();
		core_u.power_save(1'b1);
		repeat (2) @(posedge mclk);
		#1 chk("sleep clocks", 5'b00010,
			{cpuClkEn, perClkEn, oscRunEn, lprcRunEn, fscmActive});
		if (k == 4) ticks(16);
		else begin
			@(posedge mclk);
			intWake <= (k == 0);
			mclrEvt <= (k == 1);
			porEvt <= (k == 2);
			borEvt <= (k == 3);
			@(posedge mclk);
			mclrEvt <= 1'b0;
			porEvt <= 1'b0;
			borEvt <= 1'b0;
		end
		wait_cpu(c);
		intWake <= 1'b0;
		chk("woke", 1, c < 4000);
		apb(26'h0001d00, 1'b0, 32'h0, rd, er);
		chk("wake flags", flags, rd & mask);
		$display("sleep case %0d done", k);
	endtask

	// Hang guard
	initial begin
		#160000;
		miscompares++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, intWake, porEvt, borEvt, mclrEvt, lprcTick} = '0;
		paddr = '0;
		pwdata = '0;
		oscStable = 1'b1;
		pllLock = 1'b0;
		{miscompares, checks_done, resetSeen, isrSeen, trapSeen} = '0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1 chk("reset osc", 32'h1, currentOsc);
		chk("reset outs", 32'hf8, {cpuClkEn, perClkEn, oscRunEn, lprcRunEn, fscmActive,
			devReset, isrGo, clkFailTrap});
		for (i = 0; i < 9; i++) begin
			apb(rows[i].addr, rows[i].wr, rows[i].data, rd, er);
			chk("slverr", rows[i].err, er);
			if (!rows[i].wr) chk("rdata", rows[i].exp, rd);
		end
		$display("register rows done");
		// Feed just before expiry, then one tick more
		core_u.clear_wdt();
		ticks(15);
		core_u.clear_wdt();
		ticks(15);
		repeat (4) @(posedge mclk);
		chk("no early reset", 0, resetSeen);
		ticks(1);
		repeat (4) @(posedge mclk);
		chk("wdt reset", 1, resetSeen);
		wait_cpu(n);
		apb(26'h0001d00, 1'b0, 32'h0, rd, er);
		chk("timeout flag", 32'h10, rd & 32'h10);
		ticks(15);
		repeat (4) @(posedge mclk);
		chk("count restarted", 1, resetSeen);
		$display("watchdog awake done");
		// Config bit off, then software enable
		apb(26'h3e00008, 1'b1, 32'h0, rd, er);
		ticks(16);
		repeat (4) @(posedge mclk);
		chk("wdt off", 1, resetSeen);
		core_u.clear_wdt();
		apb(26'h0001d00, 1'b1, 32'h20, rd, er);
		ticks(16);
		repeat (4) @(posedge mclk);
		chk("sw enable", 2, resetSeen);
		wait_cpu(n);
		apb(26'h3e00008, 1'b1, 32'h8000, rd, er);
		$display("software enable done");
		// Idle keeps peripherals clocked
		core_u.power_save(1'b0);
		repeat (2) @(posedge mclk);
		#1 chk("idle clocks", 2'b01, {cpuClkEn, perClkEn});
		@(posedge mclk);
		intWake <= 1'b1;
		repeat (4) @(posedge mclk);
		intWake <= 1'b0;
		chk("idle isr", 1, isrSeen);
		chk("idle cpu", 1, cpuClkEn);
		$display("idle done");
		sleep_case(0, 32'h08, 32'h18, n);
		chk("fast wake delay", 1, n >= 2498 && n <= 2506);
		chk("sleep isr", 2, isrSeen);
		sleep_case(4, 32'h18, 32'h18, n);
		chk("no wdt reset in sleep", 2, resetSeen);
		sleep_case(1, 32'h08, 32'h09, n);
		apb(26'h3e00010, 1'b1, 32'h80, rd, er);
		sleep_case(3, 32'h0a, 32'h0a, n);
		sleep_case(2, 32'h01, 32'h09, n);
		// Switch to the PLL and wake with it unlocked: the clock monitor must trap
		apb(26'h0001d08, 1'b1, 32'h00000401, rd, er);
		#1 chk("switched osc", 32'h4, currentOsc);
		sleep_case(0, 32'h8008, 32'h8008, n);
		chk("pll trap delay", 1, n >= 2541 && n <= 2549);
		chk("trap pulse", 1, trapSeen);
		chk("trap osc", 32'h1, currentOsc);
		chk("trap isr", 3, isrSeen);
		$display("clock fail trap done");
		report_and_stop();
	end
endmodule
